// ### pif_pkg.sv
// shared offsets, field positions and reset values of the event flag block
package pif_pkg;

    // ****************************************************
    // register offsets on the register strobe port
    // ****************************************************
    localparam logic [7:0] SYS_FLAGS_ADDR = 8'h01;  // system_event_flags
    localparam logic [7:0] LSW_FLAGS_ADDR = 8'h02;  // load_switch_event_flags
    localparam logic [7:0] SYS_MASK_ADDR = 8'h03;   // system_event_mask
    localparam logic [7:0] STATUS_ADDR = 8'h05;     // live pin levels

    // ****************************************************
    // reset values
    // ****************************************************
    localparam logic [7:0] SYS_FLAGS_RESET = 8'h00;
    localparam logic [7:0] LSW_FLAGS_RESET = 8'h00;
    localparam logic [7:0] SYS_MASK_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ****************************************************
    // system event field positions
    // ****************************************************
    localparam int LOW_PROGRAM_SUPPLY_BIT = 5;
    localparam int MAINS_DETECT_CHANGE_BIT = 4;
    localparam int BUTTON_CHANGE_BIT = 3;
    localparam int THERMAL_WARNING_BIT = 2;
    localparam int BACKUP_CELL_DONE_BIT = 1;
    localparam int NVM_PROGRAM_DONE_BIT = 0;

    // ****************************************************
    // load-switch field positions and status positions
    // ****************************************************
    localparam int SWITCH_FAULT_LSB = 3;  // bits 5..3: switch three..one
    localparam int SWITCH_LIMIT_LSB = 0;  // bits 2..0: switch three..one
    localparam int STATUS_MAINS_BIT = 5;
    localparam int STATUS_BUTTON_BIT = 4;

    // ****************************************************
    // widths
    // ****************************************************
    localparam int EVENT_BITS = 6;   // live bits below the reserved pair
    localparam int SWITCH_COUNT = 3;

endpackage : pif_pkg

// ### pif_sticky.sv
// sticky event flags with clear on read, a new event beats the clear
`timescale 1ns/1ps

module pif_sticky #(
    parameter int WIDTH = 4
) (
    input wire logic clk,                 // register clock
    input wire logic reset,               // async reset, active high
    input wire logic [WIDTH-1:0] set,     // one-cycle event pulses
    input wire logic clear,               // read of the owning register
    output logic [WIDTH-1:0] flag         // latched flags
);

    // ****************************************************
    // one cell per flag
    // ****************************************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_cell
            // set wins so an event in the read cycle is not lost
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    flag[i] <= 1'b0;
                end else if (set[i]) begin
                    flag[i] <= 1'b1;
                end else if (clear) begin
                    flag[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule : pif_sticky

// ### pif_flags.sv
// interrupt flags, system event mask and interrupt pin of the power device
`timescale 1ns/1ps

// Functional notes
// - low program supply sets bit five
// - mains-detect edge either way sets bit four
// - button edge either way sets bit three
// - bit two follows thermal warning level
// - backup cell measure done sets bit one
// - nvm program done sets bit zero
// - switch three thermal off shows bit five
// - switch two fault shows bit four
// - switch one thermal off shows bit three
// - limit bits follow each switch's limiting
// - load-switch flags read-only at 0x02
// - mask read-write at 0x03, reset zero
// - unmasked event pulls interrupt pin low
// - flags record events whatever the mask
// - pin levels readable in status register
// - system flags reset zero, top bits zero
module pif_flags (
    input wire logic clk,                  // register clock, 25 MHz
    input wire logic reset,                // async reset, active high
    input wire logic [7:0] reg_addr,       // register offset
    input wire logic reg_wr,               // write strobe, one cycle
    input wire logic reg_rd,               // read strobe, one cycle
    input wire logic [7:0] reg_wdata,      // write data
    output logic [7:0] reg_rdata,          // read data, next cycle
    input wire logic low_supply_evt,       // supply too low to program
    input wire logic mains_detect_in_n,    // mains-detect pin level
    input wire logic button_in_n,          // push-button pin level
    input wire logic thermal_hot,          // above early warning level
    input wire logic backup_cell_done_evt, // cell comparators settled
    input wire logic nvm_done_evt,         // default programming done
    input wire logic [2:0] switch_fault,   // switch off: three,two,one
    input wire logic [2:0] switch_limit,   // current limit: three,two,one
    output logic interrupt_out_n           // interrupt pin, active low
);

    // ****************************************************
    // state
    // ****************************************************
    logic [7:0] system_event_mask;
    logic [7:0] load_switch_event_flags;
    logic [5:0] sticky_flag;   // bits 5,4,3,1,0 used; 2 is a live level
    logic [5:0] sticky_set;
    logic sys_read;
    logic thermal_warning_flag;
    logic mains_prev;
    logic button_prev;
    logic primed;
    logic mains_state;
    logic button_state;
    logic [7:0] system_event_flags;
    logic [7:0] next_rdata;
    logic pending;

    // address decode used by the flag clear and the mask write
    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] target);
        hit = (addr == target);
    endfunction : hit

    assign sys_read = reg_rd && hit(reg_addr, pif_pkg::SYS_FLAGS_ADDR);

    // ****************************************************
    // edge history of the two monitored pins
    // ****************************************************
    // primed blocks a false edge on the first sample after reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mains_prev <= 1'b1;
            button_prev <= 1'b1;
            primed <= 1'b0;
        end else begin
            mains_prev <= mains_detect_in_n;
            button_prev <= button_in_n;
            primed <= 1'b1;
        end
    end

    // live pin levels, active when the pin is low
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mains_state <= 1'b0;
            button_state <= 1'b0;
        end else begin
            mains_state <= ~mains_detect_in_n;
            button_state <= ~button_in_n;
        end
    end

    // ****************************************************
    // system event sources
    // ****************************************************
    // sources never look at the mask, so recording is unconditional
    always_comb begin
        sticky_set = '0;
        sticky_set[pif_pkg::LOW_PROGRAM_SUPPLY_BIT] = low_supply_evt;
        sticky_set[pif_pkg::MAINS_DETECT_CHANGE_BIT] =
            primed && (mains_detect_in_n != mains_prev);
        sticky_set[pif_pkg::BUTTON_CHANGE_BIT] =
            primed && (button_in_n != button_prev);
        sticky_set[pif_pkg::BACKUP_CELL_DONE_BIT] =
            backup_cell_done_evt;
        sticky_set[pif_pkg::NVM_PROGRAM_DONE_BIT] = nvm_done_evt;
    end

    // latched flags cleared by a read of the system register
    pif_sticky #(
        .WIDTH(pif_pkg::EVENT_BITS)
    ) u_sticky (
        .clk(clk),
        .reset(reset),
        .set(sticky_set),
        .clear(sys_read),
        .flag(sticky_flag)
    );

    // thermal warning is a level, it reads as the present condition
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            thermal_warning_flag <= 1'b0;
        end else begin
            thermal_warning_flag <= thermal_hot;
        end
    end

    // assembled view, reserved bits forced to zero
    always_comb begin
        system_event_flags = pif_pkg::SYS_FLAGS_RESET;
        system_event_flags[5:3] = sticky_flag[5:3];
        system_event_flags[pif_pkg::THERMAL_WARNING_BIT] =
            thermal_warning_flag;
        system_event_flags[1:0] = sticky_flag[1:0];
    end

    // ****************************************************
    // load-switch flags
    // ****************************************************
    // both groups mirror the switch condition, no latching
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            load_switch_event_flags <= pif_pkg::LSW_FLAGS_RESET;
        end else begin
            load_switch_event_flags <= '0;
            load_switch_event_flags[pif_pkg::SWITCH_FAULT_LSB +: 3] <=
                switch_fault;
            load_switch_event_flags[pif_pkg::SWITCH_LIMIT_LSB +: 3] <=
                switch_limit;
        end
    end

    // ****************************************************
    // system event mask register
    // ****************************************************
    // reserved bits are not stored and read as zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            system_event_mask <= pif_pkg::SYS_MASK_RESET;
        end else if (reg_wr && hit(reg_addr, pif_pkg::SYS_MASK_ADDR)) begin
            system_event_mask <= {2'b00, reg_wdata[5:0]};
        end
    end

    // ****************************************************
    // read path
    // ****************************************************
    // writes to read-only or unmapped offsets are dropped silently
    always_comb begin
        next_rdata = pif_pkg::UNMAPPED_READ;
        case (reg_addr)
            pif_pkg::SYS_FLAGS_ADDR: begin
                next_rdata = system_event_flags;
            end
            pif_pkg::LSW_FLAGS_ADDR: begin
                next_rdata = load_switch_event_flags;
            end
            pif_pkg::SYS_MASK_ADDR: begin
                next_rdata = system_event_mask;
            end
            pif_pkg::STATUS_ADDR: begin
                next_rdata[pif_pkg::STATUS_MAINS_BIT] = mains_state;
                next_rdata[pif_pkg::STATUS_BUTTON_BIT] = button_state;
            end
            default: begin
                next_rdata = pif_pkg::UNMAPPED_READ;
            end
        endcase
    end

    // data holds until the next read strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= pif_pkg::UNMAPPED_READ;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ****************************************************
    // interrupt pin
    // ****************************************************
    // load-switch flags have no mask here, so they always pull low
    assign pending = (|(system_event_flags[5:0] & ~system_event_mask[5:0]))
                     || (|load_switch_event_flags[5:0]);

    // registered so the pin never glitches on flag updates
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            interrupt_out_n <= 1'b1;
        end else begin
            interrupt_out_n <= ~pending;
        end
    end

    // ****************************************************
    // checks
    // ****************************************************
    a_supply_flag_set: assert property (
        @(posedge clk) disable iff (reset)
        low_supply_evt |=> system_event_flags[5])
        else $error("low supply event not recorded");

    a_mains_edge_set: assert property (
        @(posedge clk) disable iff (reset)
        primed && (mains_detect_in_n != mains_prev)
        |=> system_event_flags[4])
        else $error("mains-detect change not recorded");

    a_button_edge_set: assert property (
        @(posedge clk) disable iff (reset)
        ($fell(button_in_n) || $rose(button_in_n)) && primed
        |=> system_event_flags[3])
        else $error("button change not recorded");

    a_thermal_level: assert property (
        @(posedge clk) disable iff (reset)
        thermal_hot [*2] |=> system_event_flags[2])
        else $error("thermal warning not shown");

    a_thermal_clear: assert property (
        @(posedge clk) disable iff (reset)
        !thermal_hot ##1 !thermal_hot |=> !system_event_flags[2])
        else $error("thermal warning shown while cool");

    a_cell_done_set: assert property (
        @(posedge clk) disable iff (reset)
        backup_cell_done_evt |=> system_event_flags[1])
        else $error("cell measure done not recorded");

    a_nvm_done_set: assert property (
        @(posedge clk) disable iff (reset)
        nvm_done_evt |=> system_event_flags[0])
        else $error("program done not recorded");

    a_switch_fault: assert property (
        @(posedge clk) disable iff (reset)
        1'b1 |=> load_switch_event_flags[5:3] == $past(switch_fault))
        else $error("switch fault bits wrong");

    a_switch_limit: assert property (
        @(posedge clk) disable iff (reset)
        1'b1 |=> load_switch_event_flags[2:0] == $past(switch_limit))
        else $error("switch limit bits wrong");

    a_mask_write: assert property (
        @(posedge clk) disable iff (reset)
        reg_wr && reg_addr == pif_pkg::SYS_MASK_ADDR
        |=> system_event_mask == {2'b00, $past(reg_wdata[5:0])})
        else $error("mask write not stored");

    a_irq_assert: assert property (
        @(posedge clk) disable iff (reset)
        |(system_event_flags[5:0] & ~system_event_mask[5:0])
        |=> !interrupt_out_n)
        else $error("unmasked event did not pull pin");

    a_irq_release: assert property (
        @(posedge clk) disable iff (reset)
        !pending |=> interrupt_out_n)
        else $error("pin held with nothing pending");

    a_masked_record: assert property (
        @(posedge clk) disable iff (reset)
        nvm_done_evt && system_event_mask[0]
        |=> system_event_flags[0] && interrupt_out_n == $past(~pending))
        else $error("masked event not recorded");

    a_read_clear: assert property (
        @(posedge clk) disable iff (reset)
        sys_read && sticky_set == '0
        |=> sticky_flag == '0 && reg_rdata[5] == $past(sticky_flag[5]))
        else $error("read did not clear flags");

    a_status_level: assert property (
        @(posedge clk) disable iff (reset)
        reg_rd && reg_addr == pif_pkg::STATUS_ADDR
        |=> reg_rdata[5] == $past(mains_state)
            && reg_rdata[4] == $past(button_state))
        else $error("status levels wrong");

    a_reserved_zero: assert property (
        @(posedge clk) disable iff (reset)
        reg_rdata[7:6] == 2'b00 && system_event_flags[7:6] == 2'b00)
        else $error("reserved bits not zero");

    // per-switch views of the mirrored fault bits
    a_fault_three: assert property (
        @(posedge clk) disable iff (reset)
        switch_fault[2] |=> load_switch_event_flags[5])
        else $error("switch three fault not shown");

    a_fault_two: assert property (
        @(posedge clk) disable iff (reset)
        switch_fault[1] |=> load_switch_event_flags[4])
        else $error("switch two fault not shown");

    a_fault_one_clear: assert property (
        @(posedge clk) disable iff (reset)
        !switch_fault[0] |=> !load_switch_event_flags[3])
        else $error("switch one fault shown while normal");

    // register data lags the switch inputs by two edges; primed keeps
    // the reset value from being compared with stale inputs
    a_lsw_read: assert property (
        @(posedge clk) disable iff (reset)
        primed && reg_rd && reg_addr == pif_pkg::LSW_FLAGS_ADDR
        |=> reg_rdata == {2'b00, $past(switch_fault, 2),
                          $past(switch_limit, 2)})
        else $error("load-switch read data wrong");

    // read data stands until the next read strobe
    a_rdata_hold: assert property (
        @(posedge clk) disable iff (reset)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    // a level flag is recorded even while its mask bit is set
    a_masked_thermal: assert property (
        @(posedge clk) disable iff (reset)
        thermal_hot && system_event_mask[2] |=> system_event_flags[2])
        else $error("masked thermal warning not recorded");

endmodule : pif_flags

// ### pif_host.sv
// host model driving the register strobe port and noting expected reads
`timescale 1ns/1ps

module pif_host (
    input wire logic clk,          // register clock
    output logic [7:0] reg_addr,   // register offset
    output logic reg_wr,           // write strobe
    output logic reg_rd,           // read strobe
    output logic [7:0] reg_wdata   // write data
);
    logic [7:0] exp_q[$]; // expected read data, oldest first

    // idle port at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // ****************************************************
    // bus cycles
    // ****************************************************
    // idle lines are inverted so a stale address never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr

    // servicing read, the note is taken off by the bench monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        exp_q.push_back(e);
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask : rd
endmodule : pif_host

// ### pif_flags_tb.sv
// self-checking bench for the interrupt flags and mask block
`timescale 1ns/1ps

module pif_flags_tb;
    logic clk;
    logic reset;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic low_supply_evt;
    logic mains_detect_in_n;
    logic button_in_n;
    logic thermal_hot;
    logic backup_cell_done_evt;
    logic nvm_done_evt;
    logic [2:0] switch_fault;
    logic [2:0] switch_limit;
    logic interrupt_out_n;
    logic pend;
    int n_errors;
    int cmp_count;
    logic [31:0] seed;
    logic [31:0] rnd;
    logic [7:0] mval;

    pif_host i_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata));

    pif_flags i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .low_supply_evt(low_supply_evt),
        .mains_detect_in_n(mains_detect_in_n), .button_in_n(button_in_n),
        .thermal_hot(thermal_hot),
        .backup_cell_done_evt(backup_cell_done_evt),
        .nvm_done_evt(nvm_done_evt), .switch_fault(switch_fault),
        .switch_limit(switch_limit), .interrupt_out_n(interrupt_out_n));

    // ****************************************************
    // checking and closing
    // ****************************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done;
        // a note left on the queue means a read never completed
        if (i_host.exp_q.size() != 0) begin
            n_errors++;
        end
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    // read data is settled by the falling edge after the taking edge
    always @(posedge clk) pend <= reg_rd;
    always @(negedge clk) begin
        if (pend === 1'b1) begin
            if (i_host.exp_q.size() > 0) begin
                chk(reg_rdata, i_host.exp_q.pop_front());
            end else begin
                n_errors++;
                $display("ERROR at %0t: read with no expectation", $time);
            end
        end
    end

    // clock and watchdog, the run needs well under 2000 cycles
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        test_done();
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    // one event on system bit b; pulses last one cycle, pins toggle
    task automatic fire(input int b);
        @(negedge clk);
        case (b)
            5: low_supply_evt = 1'b1;
            4: mains_detect_in_n = ~mains_detect_in_n;
            3: button_in_n = ~button_in_n;
            2: thermal_hot = 1'b1;
            1: backup_cell_done_evt = 1'b1;
            default: nvm_done_evt = 1'b1;
        endcase
        @(negedge clk);
        low_supply_evt = 1'b0;
        backup_cell_done_evt = 1'b0;
        nvm_done_evt = 1'b0;
    endtask : fire

    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        seed = 32'h6610eb03;
        n_errors = 0;
        cmp_count = 0;
        reset = 1'b1;
        low_supply_evt = 1'b0;
        mains_detect_in_n = 1'b1;
        button_in_n = 1'b1;
        thermal_hot = 1'b0;
        backup_cell_done_evt = 1'b0;
        nvm_done_evt = 1'b0;
        switch_fault = 3'h0;
        switch_limit = 3'h0;
        cyc(6);
        reset = 1'b0;
        // reset values, unmapped read, writes to read-only places
        i_host.rd(pif_pkg::SYS_FLAGS_ADDR, 8'h00);
        i_host.rd(pif_pkg::LSW_FLAGS_ADDR, 8'h00);
        i_host.rd(pif_pkg::SYS_MASK_ADDR, 8'h00);
        i_host.rd(pif_pkg::STATUS_ADDR, 8'h00);
        i_host.rd(8'h7f, pif_pkg::UNMAPPED_READ);
        i_host.wr(pif_pkg::SYS_FLAGS_ADDR, 8'hff);
        i_host.rd(pif_pkg::SYS_FLAGS_ADDR, 8'h00);
        i_host.wr(pif_pkg::SYS_MASK_ADDR, 8'hff);
        i_host.rd(pif_pkg::SYS_MASK_ADDR, 8'h3f);
        chk(8'(interrupt_out_n), 8'h01);
        // each system event, unmasked then masked, random other mask bits
        for (int b = 0; b < 6; b++) begin
            for (int m = 0; m < 2; m++) begin
                rnd = $random(seed);
                mval = rnd[7:0];
                mval[b] = m[0];
                i_host.wr(pif_pkg::SYS_MASK_ADDR, mval);
                i_host.rd(pif_pkg::SYS_MASK_ADDR, mval & 8'h3f);
                fire(b);
                cyc(2);
                chk(8'(interrupt_out_n), 8'(m));
                i_host.rd(pif_pkg::SYS_FLAGS_ADDR, 8'h01 << b);
                thermal_hot = 1'b0;
                i_host.rd(pif_pkg::STATUS_ADDR,
                    {2'b00, ~mains_detect_in_n, ~button_in_n, 4'h0});
                cyc(2);
                chk(8'(interrupt_out_n), 8'h01);
                i_host.rd(pif_pkg::SYS_FLAGS_ADDR, 8'h00);
            end
        end
        // a new event in the cycle of the clearing read survives it
        fork
            i_host.rd(pif_pkg::SYS_FLAGS_ADDR, 8'h00);
            fire(0);
        join
        i_host.rd(pif_pkg::SYS_FLAGS_ADDR, 8'h01);
        i_host.rd(pif_pkg::SYS_FLAGS_ADDR, 8'h00);
        // load-switch levels are live, unmasked, not cleared, not writable
        repeat (6) begin
            @(negedge clk);
            rnd = $random(seed);
            switch_fault = rnd[2:0];
            switch_limit = rnd[6:4];
            cyc(3);
            chk(8'(interrupt_out_n),
                8'(~|{switch_fault, switch_limit}));
            i_host.rd(pif_pkg::LSW_FLAGS_ADDR,
                {2'b00, switch_fault, switch_limit});
            i_host.wr(pif_pkg::LSW_FLAGS_ADDR, 8'hff);
            i_host.rd(pif_pkg::LSW_FLAGS_ADDR,
                {2'b00, switch_fault, switch_limit});
        end
        switch_fault = 3'h7;
        switch_limit = 3'h7;
        cyc(3);
        i_host.rd(pif_pkg::LSW_FLAGS_ADDR, 8'h3f);
        switch_fault = 3'h0;
        switch_limit = 3'h0;
        cyc(3);
        chk(8'(interrupt_out_n), 8'h01);
        i_host.rd(pif_pkg::LSW_FLAGS_ADDR, 8'h00);
        cyc(3);
        // a reset in mid-run drops flags and mask and frees the pin
        i_host.wr(pif_pkg::SYS_MASK_ADDR, 8'h3e);
        fire(0);
        cyc(2);
        chk(8'(interrupt_out_n), 8'h00);
        reset = 1'b1;
        cyc(2);
        chk(8'(interrupt_out_n), 8'h01);
        reset = 1'b0;
        i_host.rd(pif_pkg::SYS_FLAGS_ADDR, 8'h00);
        i_host.rd(pif_pkg::SYS_MASK_ADDR, 8'h00);
        cyc(3);
        test_done();
    end
endmodule : pif_flags_tb
